// File: design/core_bus_arbiter_pkg.sv
// shared constants and types for the core bus request arbiter
`default_nettype none
package core_bus_arbiter_pkg;
  localparam int          ADDR_W      = 32;
  localparam int          DATA_W      = 32;
  localparam int          LINE_LSB    = 4;
  localparam logic [2:0]  QUAD_WORDS  = 3'h4;
  localparam logic [2:0]  ONE_WORD    = 3'h1;
  localparam logic [31:0] WORD_BYTES  = 32'h4;
  localparam logic [1:0]  SZ_WORD     = 2'h3;
  localparam logic [1:0]  PW_32       = 2'h0;
  localparam logic [1:0]  PW_16       = 2'h1;
  localparam logic [1:0]  PW_8        = 2'h2;
  typedef enum logic [2:0] {
    ST_IDLE, ST_REFRESH, ST_READ, ST_WRITE, ST_DMA_WRITE
  } arb_state_type;
endpackage
`default_nettype wire

// File: design/read_queue.sv
// small word queue used as the refill read buffer
`default_nettype none
module read_queue #(
  parameter int W     = 32,
  parameter int DEPTH = 4
) (
  input  wire logic         sys_clk_i,
  input  wire logic         nrst_i,
  input  wire logic         push_i,
  input  wire logic [W-1:0] push_data_i,
  input  wire logic         pop_i,
  output logic      [W-1:0] head_o,
  output logic              empty_o,
  output logic              full_o
);
  localparam int PW = $clog2(DEPTH);
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("read_queue depth must be a power of two");
  end
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wp;
    logic [PW-1:0]           rp;
    logic [PW:0]             cnt;
  } q_type;
  q_type q_reg;
  q_type q_next;
  logic do_push;
  logic do_pop;

  assign empty_o = q_reg.cnt == '0;
  assign full_o  = q_reg.cnt == (PW + 1)'(DEPTH);
  assign head_o  = q_reg.mem[q_reg.rp];
  assign do_push = push_i && !full_o;
  assign do_pop  = pop_i && !empty_o;

  always_comb begin
    q_next = q_reg;
    if (do_push) begin
      q_next.mem[q_reg.wp] = push_data_i;
      q_next.wp            = q_reg.wp + 1'b1;
    end
    if (do_pop) begin
      q_next.rp = q_reg.rp + 1'b1;
    end
    q_next.cnt = q_reg.cnt + (PW + 1)'(do_push) - (PW + 1)'(do_pop);
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end
endmodule
`default_nettype wire

// File: design/core_bus_request_arbiter.sv
// execution core request selection and bus interface service arbiter
// How it works
// - instruction miss reads four-word block
// - data miss: block or single per enable
// - uncacheable reads are single datum, sized
// - four-word read buffer queues refill data
// - back-to-back words accepted after any latency
// - every store enters write buffer singly
// - dma quad: read four, then write four
// - narrow memory: gather reads, split writes
// - core and cached dma reads never see stale buffered write data
// - data miss presented before instruction miss
// - full write buffer resolved before instruction miss
// - pending refresh goes first
// - running transaction always finishes uninterrupted
// - dma next; cached dma drains writes first
// - then imiss, writes, data or uncached reads
// - uncached fetch waits for empty write buffer
// - each cycle is run or stall
// - run cycle moves one instruction/data pair
// - streaming counts read buffer drain cycles
// - holds writes and two misses during dma
// - refill acknowledge with first word, three cycles before last of a back-to-back quad
`default_nettype none
module core_bus_request_arbiter #(
  parameter int WB_DEPTH = 4
) (
  input  wire logic                                      sys_clk_i,
  input  wire logic                                      nrst_i,
  input  wire logic                                      icache_miss_i,
  input  wire logic                                      icache_uncached_i,
  input  wire logic [core_bus_arbiter_pkg::ADDR_W-1:0]   icache_addr_i,
  input  wire logic                                      dcache_miss_i,
  input  wire logic                                      dcache_uncached_i,
  input  wire logic [1:0]                                dcache_size_i,
  input  wire logic [core_bus_arbiter_pkg::ADDR_W-1:0]   dcache_addr_i,
  input  wire logic                                      data_block_refill_enable_i,
  input  wire logic                                      store_valid_i,
  input  wire logic [1:0]                                store_size_i,
  input  wire logic [core_bus_arbiter_pkg::ADDR_W-1:0]   store_addr_i,
  input  wire logic [core_bus_arbiter_pkg::DATA_W-1:0]   store_data_i,
  input  wire logic                                      refresh_req_i,
  input  wire logic                                      refresh_done_i,
  input  wire logic                                      dma_req_i,
  input  wire logic                                      dma_quad_i,
  input  wire logic                                      dma_uses_cache_i,
  input  wire logic [core_bus_arbiter_pkg::ADDR_W-1:0]   dma_src_i,
  input  wire logic [core_bus_arbiter_pkg::ADDR_W-1:0]   dma_dst_i,
  input  wire logic [1:0]                                port_width_i,
  input  wire logic                                      acc_ack_i,
  input  wire logic [core_bus_arbiter_pkg::DATA_W-1:0]   acc_rdata_i,
  output logic                                           acc_req_o,
  output logic                                           acc_we_o,
  output logic      [core_bus_arbiter_pkg::ADDR_W-1:0]   acc_addr_o,
  output logic      [core_bus_arbiter_pkg::DATA_W-1:0]   acc_wdata_o,
  output logic                                           refresh_go_o,
  output logic                                           dma_done_o,
  output logic                                           core_refill_acknowledge_o,
  output logic                                           core_rvalid_o,
  output logic      [core_bus_arbiter_pkg::DATA_W-1:0]   core_rdata_o,
  output logic                                           stream_cycle_o,
  output logic                                           run_cycle_o
);
  import core_bus_arbiter_pkg::*;
  localparam int WBP = $clog2(WB_DEPTH);
  if (WB_DEPTH < 2 || (WB_DEPTH & (WB_DEPTH - 1)) != 0) begin : g_chk
    $error("write buffer depth must be a power of two");
  end

  typedef struct packed {
    arb_state_type                  st;
    logic                           i_pend;
    logic                           i_unc;
    logic [ADDR_W-1:0]              i_addr;
    logic                           d_pend;
    logic                           d_blk;
    logic [1:0]                     d_size;
    logic [ADDR_W-1:0]              d_addr;
    logic                           s_pend;
    logic [1:0]                     s_size;
    logic [ADDR_W-1:0]              s_addr;
    logic [DATA_W-1:0]              s_data;
    logic [WB_DEPTH-1:0][ADDR_W-1:0] wb_addr;
    logic [WB_DEPTH-1:0][DATA_W-1:0] wb_data;
    logic [WB_DEPTH-1:0][1:0]       wb_size;
    logic [WBP-1:0]                 wb_hd;
    logic [WBP-1:0]                 wb_tl;
    logic [WBP:0]                   wb_cnt;
    logic                           cur_inst;
    logic                           dst_dma;
    logic                           first;
    logic [2:0]                     words;
    logic [2:0]                     dma_words;
    logic [1:0]                     beat;
    logic [2:0]                     nbeats;
    logic [1:0]                     size;
    logic [ADDR_W-1:0]              base;
    logic [ADDR_W-1:0]              dst;
    logic [DATA_W-1:0]              word;
    logic                           acc_req;
    logic                           acc_we;
    logic [ADDR_W-1:0]              acc_addr;
    logic [DATA_W-1:0]              acc_wdata;
    logic                           refresh_go;
    logic                           dma_done;
    logic                           ack;
    logic                           rvalid;
    logic [DATA_W-1:0]              rdata;
    logic                           stream;
    logic                           run;
  } arb_regs_type;

  arb_regs_type r_reg;
  arb_regs_type r_next;
  logic              rb_push;
  logic              rb_pop;
  logic [DATA_W-1:0] rb_wdata;
  logic [DATA_W-1:0] rb_head;
  logic              rb_empty;

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [2:0] beats_f(input logic [1:0] sz, input logic [1:0] pw);
    logic [2:0] b;
    b = 3'(sz) + 3'h1;
    unique case (pw)
      PW_32:   beats_f = 3'h1;
      PW_16:   beats_f = (b + 3'h1) >> 1;
      default: beats_f = b;
    endcase
  endfunction

  function automatic logic [4:0] shift_f(input logic [1:0] bt, input logic [1:0] pw);
    unique case (pw)
      PW_32:   shift_f = 5'h00;
      PW_16:   shift_f = {bt[0], 4'h0};
      default: shift_f = {bt, 3'h0};
    endcase
  endfunction

  function automatic logic [ADDR_W-1:0] step_f(input logic [1:0] pw);
    unique case (pw)
      PW_32:   step_f = WORD_BYTES;
      PW_16:   step_f = WORD_BYTES >> 1;
      default: step_f = WORD_BYTES >> 2;
    endcase
  endfunction

  // a read to a line still held in the write buffer must wait for the drain
  function automatic logic wb_hit_f(input arb_regs_type r, input logic [ADDR_W-1:0] a);
    logic [WBP-1:0] off;
    wb_hit_f = 1'b0;
    for (int k = 0; k < WB_DEPTH; k++) begin
      off = WBP'(k) - r.wb_hd;
      if ((WBP + 1)'(off) < r.wb_cnt && r.wb_addr[k][ADDR_W-1:LINE_LSB] == a[ADDR_W-1:LINE_LSB]) begin
        wb_hit_f = 1'b1;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  read_queue #(.W(DATA_W), .DEPTH(int'(QUAD_WORDS))) u_rbuf (
    .sys_clk_i   (sys_clk_i),
    .nrst_i      (nrst_i),
    .push_i      (rb_push),
    .push_data_i (rb_wdata),
    .pop_i       (rb_pop),
    .head_o      (rb_head),
    .empty_o     (rb_empty),
    .full_o      ()
  );

  always_comb begin
    logic              wb_empty;
    logic              i_ok;
    logic              d_ok;
    logic              last;
    logic              core_pop;
    logic              st_have;
    logic [DATA_W-1:0] g;
    logic [1:0]        ssz;
    logic [ADDR_W-1:0] sad;
    logic [DATA_W-1:0] sdt;
    logic              wb_pop;
    logic              wb_push;
    wb_empty = r_reg.wb_cnt == '0;
    wb_pop   = 1'b0;
    wb_push  = 1'b0;
    r_next          = r_reg;
    r_next.ack      = 1'b0;
    r_next.dma_done = 1'b0;
    rb_push  = 1'b0;
    rb_wdata = '0;
    last     = (3'(r_reg.beat) + 3'h1) == r_reg.nbeats;
    g        = r_reg.word | (acc_rdata_i << shift_f(r_reg.beat, port_width_i));
    if (icache_miss_i && !r_reg.i_pend) begin
      r_next.i_pend = 1'b1;
      r_next.i_addr = icache_addr_i;
      r_next.i_unc  = icache_uncached_i;
    end
    if (dcache_miss_i && !r_reg.d_pend) begin
      r_next.d_pend = 1'b1;
      r_next.d_addr = dcache_addr_i;
      r_next.d_size = dcache_size_i;
      r_next.d_blk  = data_block_refill_enable_i && !dcache_uncached_i;
    end
    // the core offers one read at a time: data first, a stuck store blocks the fetch
    d_ok = r_reg.d_pend && wb_empty;
    i_ok = r_reg.i_pend && !r_reg.d_pend && !r_reg.s_pend &&
           !(r_reg.i_unc && !wb_empty) && !wb_hit_f(r_reg, r_reg.i_addr);
    unique case (r_reg.st)
      ST_IDLE: begin
        r_next.beat  = '0;
        r_next.word  = '0;
        r_next.first = 1'b1;
        if (refresh_req_i) begin
          r_next.st         = ST_REFRESH;
          r_next.refresh_go = 1'b1;
        end else if (dma_req_i && rb_empty && (!dma_uses_cache_i || wb_empty)) begin
          r_next.st        = ST_READ;
          r_next.dst_dma   = 1'b1;
          r_next.cur_inst  = 1'b0;
          r_next.dst       = dma_dst_i;
          r_next.words     = dma_quad_i ? QUAD_WORDS : ONE_WORD;
          r_next.dma_words = r_next.words;
          r_next.size      = SZ_WORD;
          r_next.base      = dma_src_i;
        end else if (i_ok && rb_empty) begin
          r_next.st       = ST_READ;
          r_next.dst_dma  = 1'b0;
          r_next.cur_inst = 1'b1;
          r_next.words    = r_reg.i_unc ? ONE_WORD : QUAD_WORDS;
          r_next.size     = SZ_WORD;
          r_next.base     = r_reg.i_unc ? r_reg.i_addr
                            : {r_reg.i_addr[ADDR_W-1:LINE_LSB], LINE_LSB'(0)};
        end else if (!wb_empty) begin
          r_next.st      = ST_WRITE;
          r_next.dst_dma = 1'b0;
        end else if (d_ok && rb_empty) begin
          r_next.st       = ST_READ;
          r_next.dst_dma  = 1'b0;
          r_next.cur_inst = 1'b0;
          r_next.words    = r_reg.d_blk ? QUAD_WORDS : ONE_WORD;
          r_next.size     = r_reg.d_blk ? SZ_WORD : r_reg.d_size;
          r_next.base     = r_reg.d_blk ? {r_reg.d_addr[ADDR_W-1:LINE_LSB], LINE_LSB'(0)}
                            : r_reg.d_addr;
        end
        if (r_next.st == ST_READ) begin
          r_next.nbeats   = beats_f(r_next.size, port_width_i);
          r_next.acc_req  = 1'b1;
          r_next.acc_we   = 1'b0;
          r_next.acc_addr = r_next.base;
        end
      end
      ST_REFRESH: begin
        if (refresh_done_i) begin
          r_next.st         = ST_IDLE;
          r_next.refresh_go = 1'b0;
        end
      end
      ST_READ: begin
        // each word waits for its own acknowledge, so wait states before or between words are fine
        if (acc_ack_i) begin
          r_next.word = g;
          if (last) begin
            rb_push       = 1'b1;
            rb_wdata      = g;
            r_next.word   = '0;
            r_next.beat   = '0;
            r_next.first  = 1'b0;
            // first word of a back-to-back quad lands three cycles before the last
            r_next.ack    = r_reg.first && !r_reg.dst_dma;
            r_next.base   = r_reg.base + WORD_BYTES;
            r_next.acc_addr = r_reg.base + WORD_BYTES;
            r_next.words  = r_reg.words - 3'h1;
            if (r_reg.words == ONE_WORD) begin
              r_next.acc_req = 1'b0;
              if (r_reg.dst_dma) begin
                r_next.st    = ST_DMA_WRITE;
                r_next.words = r_reg.dma_words;
              end else begin
                r_next.st     = ST_IDLE;
                // a miss taken on this same edge must survive the clear
                r_next.i_pend = r_next.i_pend && !r_reg.cur_inst;
                r_next.d_pend = r_next.d_pend && r_reg.cur_inst;
              end
            end
          end else begin
            r_next.beat     = r_reg.beat + 2'h1;
            r_next.acc_addr = r_reg.acc_addr + step_f(port_width_i);
          end
        end
      end
      ST_WRITE, ST_DMA_WRITE: begin
        if (!r_reg.acc_req) begin
          // one idle cycle per word lets the source queue present its next head
          if (r_reg.st == ST_DMA_WRITE) begin
            r_next.word = rb_head;
            r_next.base = r_reg.dst;
            r_next.size = SZ_WORD;
          end else begin
            r_next.word = r_reg.wb_data[r_reg.wb_hd];
            r_next.base = r_reg.wb_addr[r_reg.wb_hd];
            r_next.size = r_reg.wb_size[r_reg.wb_hd];
          end
          r_next.nbeats    = beats_f(r_next.size, port_width_i);
          r_next.beat      = '0;
          r_next.acc_req   = 1'b1;
          r_next.acc_we    = 1'b1;
          r_next.acc_addr  = r_next.base;
          r_next.acc_wdata = r_next.word;
        end else if (acc_ack_i) begin
          if (last) begin
            r_next.acc_req = 1'b0;
            r_next.acc_we  = 1'b0;
            if (r_reg.st == ST_DMA_WRITE) begin
              r_next.dst   = r_reg.dst + WORD_BYTES;
              r_next.words = r_reg.words - 3'h1;
              if (r_reg.words == ONE_WORD) begin
                r_next.st       = ST_IDLE;
                r_next.dma_done = 1'b1;
              end
            end else begin
              wb_pop    = 1'b1;
              r_next.st = ST_IDLE;
            end
          end else begin
            r_next.beat      = r_reg.beat + 2'h1;
            r_next.acc_addr  = r_reg.acc_addr + step_f(port_width_i);
            r_next.acc_wdata = r_reg.word >> shift_f(r_reg.beat + 2'h1, port_width_i);
          end
        end
      end
    endcase
    // stores are queued one datum each and wait in place while the buffer is full
    st_have = r_reg.s_pend || store_valid_i;
    ssz = r_reg.s_pend ? r_reg.s_size : store_size_i;
    sad = r_reg.s_pend ? r_reg.s_addr : store_addr_i;
    sdt = r_reg.s_pend ? r_reg.s_data : store_data_i;
    if (st_have && r_reg.wb_cnt < (WBP + 1)'(WB_DEPTH)) begin
      wb_push                      = 1'b1;
      r_next.wb_addr[r_reg.wb_tl]  = sad;
      r_next.wb_data[r_reg.wb_tl]  = sdt;
      r_next.wb_size[r_reg.wb_tl]  = ssz;
      r_next.wb_tl                 = r_reg.wb_tl + 1'b1;
      r_next.s_pend                = 1'b0;
    end else if (store_valid_i && !r_reg.s_pend) begin
      r_next.s_pend = 1'b1;
      r_next.s_size = store_size_i;
      r_next.s_addr = store_addr_i;
      r_next.s_data = store_data_i;
    end
    if (wb_pop) begin
      r_next.wb_hd = r_reg.wb_hd + 1'b1;
    end
    r_next.wb_cnt = r_reg.wb_cnt + (WBP + 1)'(wb_push) - (WBP + 1)'(wb_pop);
    core_pop = !rb_empty && !r_reg.dst_dma;
    rb_pop   = core_pop || (r_reg.st == ST_DMA_WRITE && r_reg.acc_req && acc_ack_i && last);
    r_next.rvalid = core_pop;
    r_next.rdata  = core_pop ? rb_head : r_reg.rdata;
    r_next.stream = core_pop;
    r_next.run    = core_pop || !(r_next.i_pend || r_next.d_pend || r_next.s_pend ||
                    (dma_req_i && dma_uses_cache_i));
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign acc_req_o                 = r_reg.acc_req;
  assign acc_we_o                  = r_reg.acc_we;
  assign acc_addr_o                = r_reg.acc_addr;
  assign acc_wdata_o               = r_reg.acc_wdata;
  assign refresh_go_o              = r_reg.refresh_go;
  assign dma_done_o                = r_reg.dma_done;
  assign core_refill_acknowledge_o = r_reg.ack;
  assign core_rvalid_o             = r_reg.rvalid;
  assign core_rdata_o              = r_reg.rdata;
  assign stream_cycle_o            = r_reg.stream;
  assign run_cycle_o               = r_reg.run;

  ////////////////////////////////////////////////////////////////////////////////
  logic rd_start;
  assign rd_start = r_reg.st == ST_READ && r_reg.first && r_reg.beat == '0 && r_reg.word == '0;

  property p_imiss_quad;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (rd_start && $past(r_reg.st) == ST_IDLE && r_reg.cur_inst && !r_reg.i_unc)
      |-> r_reg.words == QUAD_WORDS;
  endproperty
  a_imiss_quad: assert property (p_imiss_quad) else $error("imiss not a quad read");

  property p_dmiss_size;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (rd_start && $past(r_reg.st) == ST_IDLE && !r_reg.cur_inst && !r_reg.dst_dma)
      |-> r_reg.words == (r_reg.d_blk ? QUAD_WORDS : ONE_WORD);
  endproperty
  a_dmiss_size: assert property (p_dmiss_size) else $error("dmiss read size wrong");

  property p_data_first;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (rd_start && $past(r_reg.st) == ST_IDLE && r_reg.cur_inst) |-> !$past(r_reg.d_pend);
  endproperty
  a_data_first: assert property (p_data_first) else $error("imiss served before dmiss");

  property p_refresh_first;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (r_reg.st == ST_IDLE && refresh_req_i) |=> r_reg.st == ST_REFRESH && refresh_go_o;
  endproperty
  a_refresh_first: assert property (p_refresh_first) else $error("refresh not taken");

  property p_no_preempt;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (r_reg.st == ST_READ && !acc_ack_i) |=> r_reg.st == ST_READ && $stable(acc_addr_o);
  endproperty
  a_no_preempt: assert property (p_no_preempt) else $error("read interrupted");

  property p_unc_fetch;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    ($past(r_reg.st) == ST_IDLE && rd_start && r_reg.cur_inst && r_reg.i_unc)
      |-> $past(r_reg.wb_cnt) == '0;
  endproperty
  a_unc_fetch: assert property (p_unc_fetch) else $error("uncached fetch passed writes");

  property p_ack_stream;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    core_refill_acknowledge_o |-> ##1 (core_rvalid_o && stream_cycle_o && run_cycle_o);
  endproperty
  a_ack_stream: assert property (p_ack_stream) else $error("no stream after acknowledge");

  property p_pend_hold;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    // only read buffer drain counts as run while a fetch waits
    (r_reg.i_pend && r_reg.st != ST_READ)
      |=> r_reg.i_pend && $stable(r_reg.i_addr) && run_cycle_o == stream_cycle_o;
  endproperty
  a_pend_hold: assert property (p_pend_hold) else $error("pending fetch dropped");

  property p_cache_dma;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (dma_req_i && dma_uses_cache_i && rd_start && r_reg.dst_dma) |-> $past(r_reg.wb_cnt) == '0;
  endproperty
  a_cache_dma: assert property (p_cache_dma) else $error("cached dma before drain");

  c_quad: cover property (@(posedge sys_clk_i) disable iff (!nrst_i)
    core_refill_acknowledge_o ##1 stream_cycle_o [*4]);
  c_dma: cover property (@(posedge sys_clk_i) disable iff (!nrst_i) dma_done_o);
  c_refresh: cover property (@(posedge sys_clk_i) disable iff (!nrst_i) $rose(refresh_go_o));
  c_narrow: cover property (@(posedge sys_clk_i) disable iff (!nrst_i)
    acc_ack_i && acc_we_o && r_reg.nbeats > ONE_WORD);
endmodule
`default_nettype wire

// File: tb/mem_model.sv
// access bus memory responder standing in for the external controllers
`default_nettype none
module mem_model (
  input  wire logic        clk_i,
  input  wire logic        req_i,
  input  wire logic [31:0] addr_i,
  input  wire logic        slow_i,
  output logic             ack_o,
  output logic      [31:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tick_reg = 1'b0;
  always_ff @(posedge clk_i) tick_reg <= ~tick_reg;
  // acks back-to-back at clock rate unless slowed
  assign ack_o = req_i & (~slow_i | tick_reg);
  // acked data is the inverted address and an unacked bus shows the address itself, so stale data never matches
  assign rdata_o = ack_o ? ~addr_i : addr_i;
endmodule
`default_nettype wire

// File: tb/core_bus_request_arbiter_test.sv
// self-checking bench for the core bus request arbiter
`default_nettype none
module core_bus_request_arbiter_test;
  timeunit 1ns;
  timeprecision 1ps;
  import core_bus_arbiter_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, im = 1'b0, dm = 1'b0, du = 1'b0, en = 1'b0;
  logic st = 1'b0, rr = 1'b0, rd = 1'b0, slow = 1'b0, dq = 1'b0, iu = 1'b0;
  logic ack, req, we, rfa, rv, sc, run, go, dd;
  logic [1:0] pw = PW_32, sz = SZ_WORD;
  logic [31:0] ia = 32'h0000_1238, da = 32'h0000_2344, sd = 32'hCAFE_1234;
  logic [31:0] ad, wd, cd, rdat, fa, wl, nx;
  int errors = 0, n_checks = 0, cyc = 0, beats, words, acks, dones;
  core_bus_request_arbiter uut (.sys_clk_i(clk), .nrst_i(nrst), .icache_miss_i(im),
    .icache_uncached_i(iu), .icache_addr_i(ia), .dcache_miss_i(dm), .dcache_uncached_i(du),
    .dcache_size_i(sz), .dcache_addr_i(da), .data_block_refill_enable_i(en),
    .store_valid_i(st), .store_size_i(sz), .store_addr_i(da), .store_data_i(sd),
    .refresh_req_i(rr), .refresh_done_i(rd), .dma_req_i(dq), .dma_quad_i(dq),
    .dma_uses_cache_i(dq), .dma_src_i(ia), .dma_dst_i(da), .port_width_i(pw),
    .acc_ack_i(ack), .acc_rdata_i(rdat), .acc_req_o(req), .acc_we_o(we), .acc_addr_o(ad),
    .acc_wdata_o(wd), .refresh_go_o(go), .dma_done_o(dd), .core_refill_acknowledge_o(rfa),
    .core_rvalid_o(rv), .core_rdata_o(cd), .stream_cycle_o(sc), .run_cycle_o(run));
  mem_model mem (.clk_i(clk), .req_i(req), .addr_i(ad), .slow_i(slow), .ack_o(ack),
    .rdata_o(rdat));
  always #2 clk = ~clk;
  //////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // sampled at the falling edge so registered outputs have settled
  task automatic watch(int n);
    beats = 0;
    words = 0;
    acks = 0;
    dones = 0;
    repeat (n) begin
      @(negedge clk);
      if (rfa === 1'b1) acks++;
      // dma request is a level held until the done pulse
      if (dd === 1'b1) begin
        dones++;
        dq = 1'b0;
      end
      if (req === 1'b1 && ack === 1'b1) begin
        if (beats == 0) fa = ad;
        if (we === 1'b1) wl = wd;
        beats++;
      end
      if (rv === 1'b1 && sc === 1'b1) begin
        if (words == 4) nx = {ia[31:LINE_LSB], 4'h0};
        chk("core data", ~nx, cd);
        nx += 4;
        words++;
      end
    end
  endtask
  task automatic miss(logic i, logic d, logic u, logic e, logic [31:0] efa, int ew);
    im = i;
    dm = d;
    du = u;
    iu = u;
    en = e;
    nx = d ? ((e & ~u) ? {da[31:LINE_LSB], 4'h0} : da) : (u ? ia : {ia[31:LINE_LSB], 4'h0});
    @(negedge clk);
    im = 1'b0;
    dm = 1'b0;
    st = 1'b0;
    watch(40);
    du = 1'b0;
    iu = 1'b0;
    chk("first address", efa, fa);
    chk("words to core", ew, words);
    chk("acknowledges", 32'(i) + 32'(d), acks);
    chk("run resumed", 1, run);
  endtask
  task automatic store_case(logic [1:0] w, logic [1:0] s, int eb, logic [31:0] ewl);
    pw = w;
    sz = s;
    st = 1'b1;
    @(negedge clk);
    st = 1'b0;
    watch(40);
    chk("write beats", eb, beats);
    chk("write data", ewl, wl);
    pw = PW_32;
    sz = SZ_WORD;
  endtask
  task automatic dma_case();
    st = 1'b1;
    @(negedge clk);
    st = 1'b0;
    dq = 1'b1;
    watch(40);
    chk("dma first access", da, fa);
    chk("dma beats", 9, beats);
    chk("dma last write", ~(ia + 32'hC), wl);
    chk("dma done", 1, dones);
    chk("run after dma", 1, run);
  endtask
  task automatic refresh_case();
    rr = 1'b1;
    repeat (2) @(negedge clk);
    chk("refresh go", 1, go);
    im = 1'b1;
    @(negedge clk);
    im = 1'b0;
    watch(6);
    rr = 1'b0;
    chk("beats in refresh", 0, beats);
    chk("stalled while held", 0, run);
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    nx = 32'h0000_1230;
    watch(30);
    chk("deferred words", 4, words);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 1500) begin
      errors++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    miss(1'b1, 1'b0, 1'b0, 1'b0, 32'h0000_1230, 4);
    miss(1'b0, 1'b1, 1'b0, 1'b1, 32'h0000_2340, 4);
    miss(1'b0, 1'b1, 1'b0, 1'b0, 32'h0000_2344, 1);
    miss(1'b0, 1'b1, 1'b1, 1'b1, 32'h0000_2344, 1);
    miss(1'b1, 1'b1, 1'b0, 1'b1, 32'h0000_2340, 8);
    slow = 1'b1;
    miss(1'b1, 1'b0, 1'b0, 1'b0, 32'h0000_1230, 4);
    slow = 1'b0;
    st = 1'b1;
    miss(1'b1, 1'b0, 1'b0, 1'b0, 32'h0000_1230, 4);
    st = 1'b1;
    miss(1'b1, 1'b0, 1'b1, 1'b0, 32'h0000_2344, 1);
    st = 1'b1;
    miss(1'b0, 1'b1, 1'b0, 1'b1, 32'h0000_2344, 4);
    store_case(PW_32, SZ_WORD, 1, sd);
    store_case(PW_16, SZ_WORD, 2, 32'h0000_CAFE);
    store_case(PW_8, 2'h1, 2, 32'h00CA_FE12);
    dma_case();
    refresh_case();
    tally_and_finish();
  end
endmodule
`default_nettype wire
